// ### irq_ctrl.sv
// Overview of operation
// - A request sets its pending flag; acknowledge or reset clears; software writes.
// - Both pending registers take bit and byte writes, reset to 00H.
// - Watchdog pending flag is accessible only in interval mode.
// - Acknowledge clears the chosen pending flag before the routine starts.
// - Block bit 0 allows, 1 blocks; bit and byte writes; reset FFH.
// - Watchdog block bit reads undefined in watchdog modes 1 and 2.
// - Two-bit field per pin: falling, rising, both; code 1,0 disallowed.
// - Edge-select registers take whole-byte writes only, reset to 00H.
// - Status word resets to 02H; bit 7 global enable; bit 1 fixed 1.
// - Status word byte and bit access; allow-all sets, mask-all clears enable.
// - Non-maskable request ignores the global enable and beats all others.
// - Non-maskable acknowledge pushes status, pushes counter, clears enable, vectors.
// - A new non-maskable request during non-maskable service is acknowledged.
// - Maskable acknowledge needs flag 1, block bit 0, global enable 1.
// - Maskable service starts 9 to 19 clocks after the request.
// - Simultaneous maskable requests are acknowledged one at a time, by priority.
// - A request not yet acceptable stays pending until conditions hold.
// - Maskable acknowledge pushes status, counter, clears enable, loads own vector.
// - Return from service restores counter and status word from the stack.
// - Priority runs from source 0, watchdog, to source 11, lowest.
// - Watchdog acts as non-maskable or maskable source, never both.
// - Flag or block register access holds all requests until it completes.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module irq_ctrl (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [17:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [17:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] wdt_mode,
  input wire logic watchdog_irq,
  input wire logic [3:0] external_irq_pin,
  input wire logic [6:0] periph_irq,
  input wire irq_ctrl_pkg::cpu_ctl_type cpu_ctl,
  output irq_ctrl_pkg::ack_type ack
);

  // ==========================================================================
  // Declarations
  logic aw_hold_ff, w_hold_ff, bvalid_ff, awready_ff, wready_ff;
  logic arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [17:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
  logic aw_take, w_take, ar_take, do_write, wr_byte;
  logic [11:0] flags_ff, blocks_ff, nxt_flags, nxt_blocks;
  logic [11:0] hw_set, eligible, ack_clr, pick_onehot;
  logic [7:0] edge0_ff, edge1_ff, psw_ff, nxt_psw;
  logic [3:0] pin_prev_ff, pin_hit;
  logic primed_ff, nmi_pend_ff, nxt_nmi_pend;
  logic interval, hold_now, accept, take_nmi, any_req;
  logic [3:0] pick_idx;
  logic [1:0] edge_sel [irq_ctrl_pkg::NPIN];
  logic [7:0] cur_reg [irq_ctrl_pkg::NREG_BIT];
  logic [7:0] sw_val [irq_ctrl_pkg::NREG_BIT];
  logic [irq_ctrl_pkg::NREG_BIT-1:0] sw_en;
  logic [7:0] rd_val;
  logic rd_ok, wr_ok;
  logic [4:0] age_ff;
  irq_ctrl_pkg::seq_type state_ff, nxt_state;
  irq_ctrl_pkg::ack_type ack_ff;

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign ack = ack_ff;

  // ==========================================================================
  // Register bus handshakes
  assign aw_take = awvalid & awready_ff;
  assign w_take = wvalid & wready_ff;
  assign ar_take = arvalid & arready_ff;
  assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_byte = do_write & wstrb0_ff;
  assign nxt_aw_hold = aw_take | (aw_hold_ff & ~do_write);
  assign nxt_w_hold = w_take | (w_hold_ff & ~do_write);
  assign nxt_bvalid = do_write | (bvalid_ff & ~bready);
  assign nxt_rvalid = ar_take | (rvalid_ff & ~rready);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_ff <= irq_ctrl_pkg::RESP_OKAY;
      awaddr_ff <= 18'h00000;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff <= ~nxt_w_hold & ~nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= awaddr;
      end
      if (w_take) begin
        wdata_ff <= wdata[7:0];
        wstrb0_ff <= wstrb[0];
      end
      if (do_write) begin
        bresp_ff <= wr_ok ? irq_ctrl_pkg::RESP_OKAY
                          : irq_ctrl_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // Software write decode, byte and bit forms
  always_comb begin
    cur_reg[0] = flags_ff[7:0];
    cur_reg[1] = {irq_ctrl_pkg::PEND1_FILL, flags_ff[11:8]};
    cur_reg[2] = blocks_ff[7:0];
    cur_reg[3] = {irq_ctrl_pkg::BLOCK1_FILL, blocks_ff[11:8]};
    cur_reg[4] = psw_ff;
    sw_en = '0;
    wr_ok = 1'b1;
    for (int r = 0; r < irq_ctrl_pkg::NREG_BIT; r++) begin
      sw_val[r] = cur_reg[r];
    end
    case (awaddr_ff)
      irq_ctrl_pkg::A_PEND0: sw_en[0] = wr_byte;
      irq_ctrl_pkg::A_PEND1: sw_en[1] = wr_byte;
      irq_ctrl_pkg::A_BLOCK0: sw_en[2] = wr_byte;
      irq_ctrl_pkg::A_BLOCK1: sw_en[3] = wr_byte;
      irq_ctrl_pkg::A_PSW: sw_en[4] = wr_byte;
      irq_ctrl_pkg::A_EDGE0, irq_ctrl_pkg::A_EDGE1, irq_ctrl_pkg::A_BITOP: begin
        wr_ok = 1'b1;
      end
      default: wr_ok = 1'b0;
    endcase
    for (int r = 0; r < irq_ctrl_pkg::NREG_BIT; r++) begin
      if (sw_en[r]) begin
        sw_val[r] = wdata_ff;
      end
    end
    // Single-bit set or clear; edge-select registers have no bit form
    if (wr_byte && awaddr_ff == irq_ctrl_pkg::A_BITOP &&
        wdata_ff[5:3] < 3'(irq_ctrl_pkg::NREG_BIT) &&
        (wdata_ff[irq_ctrl_pkg::BITOP_SET] ^
         wdata_ff[irq_ctrl_pkg::BITOP_CLR])) begin
      sw_en[wdata_ff[5:3]] = 1'b1;
      sw_val[wdata_ff[5:3]][wdata_ff[2:0]] =
        wdata_ff[irq_ctrl_pkg::BITOP_SET];
    end
  end

  // ==========================================================================
  // Edge selection and pin edge detection
  assign interval = (wdt_mode == irq_ctrl_pkg::WDT_INTERVAL);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      edge0_ff <= irq_ctrl_pkg::EDGE_RST;
      edge1_ff <= irq_ctrl_pkg::EDGE_RST;
      pin_prev_ff <= 4'h0;
      primed_ff <= 1'b0;
    end else begin
      if (wr_byte && awaddr_ff == irq_ctrl_pkg::A_EDGE0) begin
        edge0_ff <= wdata_ff & irq_ctrl_pkg::EDGE0_MASK;
      end
      if (wr_byte && awaddr_ff == irq_ctrl_pkg::A_EDGE1) begin
        edge1_ff <= wdata_ff & irq_ctrl_pkg::EDGE1_MASK;
      end
      pin_prev_ff <= external_irq_pin;
      primed_ff <= 1'b1;
    end
  end

  always_comb begin
    edge_sel[0] = edge0_ff[3:2];
    edge_sel[1] = edge0_ff[5:4];
    edge_sel[2] = edge0_ff[7:6];
    edge_sel[3] = edge1_ff[1:0];
    for (int n = 0; n < irq_ctrl_pkg::NPIN; n++) begin
      case (edge_sel[n])
        irq_ctrl_pkg::EDGE_FALL: pin_hit[n] = ~external_irq_pin[n] &
                                              pin_prev_ff[n];
        irq_ctrl_pkg::EDGE_RISE: pin_hit[n] = external_irq_pin[n] &
                                              ~pin_prev_ff[n];
        irq_ctrl_pkg::EDGE_BOTH: pin_hit[n] = external_irq_pin[n] ^
                                              pin_prev_ff[n];
        default: pin_hit[n] = 1'b0;
      endcase
      pin_hit[n] = pin_hit[n] & primed_ff;
    end
  end

  // Watchdog feeds only one path, chosen by its mode
  assign hw_set = {periph_irq, pin_hit, watchdog_irq & interval};

  // ==========================================================================
  // Arbitration
  assign eligible = flags_ff & ~blocks_ff &
                    {irq_ctrl_pkg::NSRC{psw_ff[irq_ctrl_pkg::PSW_IE]}};

  always_comb begin
    pick_idx = 4'h0;
    for (int i = irq_ctrl_pkg::NSRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        pick_idx = 4'(i);
      end
    end
  end

  assign pick_onehot = 12'h001 << pick_idx;
  assign any_req = nmi_pend_ff | (|eligible);
  assign hold_now = cpu_ctl.flag_instr |
    (do_write && (awaddr_ff == irq_ctrl_pkg::A_PEND0 ||
     awaddr_ff == irq_ctrl_pkg::A_PEND1 ||
     awaddr_ff == irq_ctrl_pkg::A_BLOCK0 ||
     awaddr_ff == irq_ctrl_pkg::A_BLOCK1 ||
     awaddr_ff == irq_ctrl_pkg::A_BITOP)) |
    (ar_take && (araddr == irq_ctrl_pkg::A_PEND0 ||
     araddr == irq_ctrl_pkg::A_PEND1 ||
     araddr == irq_ctrl_pkg::A_BLOCK0 ||
     araddr == irq_ctrl_pkg::A_BLOCK1));
  // Unaccepted requests simply wait in their flags
  assign accept = (state_ff == irq_ctrl_pkg::ST_IDLE) & cpu_ctl.boundary &
                  ~hold_now & any_req;
  assign take_nmi = nmi_pend_ff;
  assign ack_clr = (accept && !take_nmi) ? pick_onehot : 12'h000;

  // ==========================================================================
  // Pending, block and non-maskable flags
  always_comb begin
    nxt_flags = flags_ff;
    if (sw_en[0]) begin
      nxt_flags[7:1] = sw_val[0][7:1];
      if (interval) begin
        nxt_flags[0] = sw_val[0][0];
      end
    end
    if (sw_en[1]) begin
      nxt_flags[11:8] = sw_val[1][3:0];
    end
    nxt_flags = (nxt_flags & ~ack_clr) | hw_set;
    nxt_blocks = blocks_ff;
    if (sw_en[2]) begin
      nxt_blocks[7:0] = sw_val[2];
    end
    if (sw_en[3]) begin
      nxt_blocks[11:8] = sw_val[3][3:0];
    end
    nxt_nmi_pend = (nmi_pend_ff & ~(accept & take_nmi)) |
                   (watchdog_irq & (wdt_mode == irq_ctrl_pkg::WDT_MODE1));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flags_ff <= 12'h000;
      blocks_ff <= 12'hFFF;
      nmi_pend_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      blocks_ff <= nxt_blocks;
      nmi_pend_ff <= nxt_nmi_pend;
    end
  end

  // ==========================================================================
  // Status word
  always_comb begin
    nxt_psw = psw_ff;
    if (sw_en[4]) begin
      nxt_psw = sw_val[4];
    end
    if (cpu_ctl.allow_all) begin
      nxt_psw[irq_ctrl_pkg::PSW_IE] = 1'b1;
    end
    if (cpu_ctl.mask_all) begin
      nxt_psw[irq_ctrl_pkg::PSW_IE] = 1'b0;
    end
    if (cpu_ctl.return_from_service_instr) begin
      nxt_psw = cpu_ctl.restore_psw;
    end
    if (accept) begin
      nxt_psw[irq_ctrl_pkg::PSW_IE] = 1'b0;
    end
    nxt_psw = (nxt_psw & irq_ctrl_pkg::PSW_KEEP) | irq_ctrl_pkg::PSW_ONES;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      psw_ff <= irq_ctrl_pkg::PSW_RST;
    end else begin
      psw_ff <= nxt_psw;
    end
  end

  // ==========================================================================
  // Acknowledge sequence: push status, push counter, wait, vector
  always_comb begin
    case (state_ff)
      irq_ctrl_pkg::ST_IDLE: nxt_state = accept ? irq_ctrl_pkg::ST_PSW
                                                : irq_ctrl_pkg::ST_IDLE;
      irq_ctrl_pkg::ST_PSW: nxt_state = irq_ctrl_pkg::ST_PC;
      irq_ctrl_pkg::ST_PC: nxt_state = irq_ctrl_pkg::ST_WAIT;
      irq_ctrl_pkg::ST_WAIT: nxt_state = (age_ff >= irq_ctrl_pkg::AGE_LOAD) ?
        irq_ctrl_pkg::ST_VEC : irq_ctrl_pkg::ST_WAIT;
      irq_ctrl_pkg::ST_VEC: nxt_state = irq_ctrl_pkg::ST_IDLE;
      default: nxt_state = irq_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_ff <= irq_ctrl_pkg::ST_IDLE;
      age_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == irq_ctrl_pkg::ST_IDLE && !any_req) begin
        age_ff <= 5'h00;
      end else if (age_ff != irq_ctrl_pkg::AGE_TOP) begin
        age_ff <= age_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_ff <= '0;
    end else begin
      ack_ff.push_psw <= (nxt_state == irq_ctrl_pkg::ST_PSW);
      ack_ff.push_pc <= (nxt_state == irq_ctrl_pkg::ST_PC);
      ack_ff.load_vec <= (nxt_state == irq_ctrl_pkg::ST_VEC);
      if (accept) begin
        ack_ff.nmi <= take_nmi;
        ack_ff.program_status_word <= psw_ff;
        ack_ff.vector <= take_nmi ? irq_ctrl_pkg::VEC_NMI :
          16'(irq_ctrl_pkg::VEC_BASE +
              irq_ctrl_pkg::VEC_STEP * 16'(pick_idx));
      end
    end
  end

  // ==========================================================================
  // Register reads
  always_comb begin
    rd_ok = 1'b1;
    case (araddr)
      irq_ctrl_pkg::A_PEND0:
        rd_val = {flags_ff[7:1], flags_ff[0] & interval};
      irq_ctrl_pkg::A_PEND1: rd_val = cur_reg[1];
      irq_ctrl_pkg::A_BLOCK0:
        rd_val = {blocks_ff[7:1], blocks_ff[0] & interval};
      irq_ctrl_pkg::A_BLOCK1: rd_val = cur_reg[3];
      irq_ctrl_pkg::A_EDGE0: rd_val = edge0_ff;
      irq_ctrl_pkg::A_EDGE1: rd_val = edge1_ff;
      irq_ctrl_pkg::A_PSW: rd_val = psw_ff;
      irq_ctrl_pkg::A_BITOP: rd_val = 8'h00;
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= irq_ctrl_pkg::RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= {24'h000000, rd_val};
        rresp_ff <= rd_ok ? irq_ctrl_pkg::RESP_OKAY
                          : irq_ctrl_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence seq_push;
    ack_ff.push_psw ##1 ack_ff.push_pc;
  endsequence

  chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    hw_set != 12'h000 |=> (flags_ff & $past(hw_set)) == $past(hw_set))
    else $error("pending flag lost a request");
  chk_pend_reset_val: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> flags_ff == 12'h000)
    else $error("pending flags not clear after reset");
  chk_wdt_flag_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !interval && !flags_ff[0] |=> !flags_ff[0])
    else $error("watchdog flag set outside interval mode");
  chk_ack_clears_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    accept && !take_nmi && (hw_set & pick_onehot) == 12'h000
    |=> (flags_ff & $past(pick_onehot)) == 12'h000)
    else $error("acknowledged flag not cleared");
  chk_block_reset_val: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> blocks_ff == 12'hFFF && edge0_ff == 8'h00)
    else $error("block flags or edge select wrong after reset");
  chk_psw_reset_val: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> psw_ff == 8'h02)
    else $error("status word wrong after reset");
  chk_nmi_no_enable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_ff == irq_ctrl_pkg::ST_IDLE && cpu_ctl.boundary && !hold_now &&
    nmi_pend_ff |=> ack_ff.push_psw && ack_ff.nmi)
    else $error("non-maskable request not taken");
  chk_ack_sequence: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(ack_ff.push_psw) |-> seq_push ##[1:20] ack_ff.load_vec)
    else $error("acknowledge steps out of order");
  chk_enable_cleared: assert property (@(posedge ref_clk) disable iff (!rst_b)
    accept |=> !psw_ff[irq_ctrl_pkg::PSW_IE])
    else $error("global enable not cleared on acknowledge");
  chk_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    accept && !nmi_pend_ff |-> psw_ff[irq_ctrl_pkg::PSW_IE] &&
    (flags_ff & ~blocks_ff & pick_onehot) != 12'h000)
    else $error("maskable request taken while gated");
  chk_svc_min_time: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(ack_ff.load_vec) |->
    age_ff >= 5'(irq_ctrl_pkg::SVC_MIN_CLK - 1))
    else $error("service started too early");
  chk_priority_order: assert property (@(posedge ref_clk) disable iff (!rst_b)
    accept && !take_nmi |-> (eligible & (pick_onehot - 12'h001)) == 12'h000)
    else $error("lower priority source chosen");
  chk_hold_blocks: assert property (@(posedge ref_clk) disable iff (!rst_b)
    hold_now |=> !ack_ff.push_psw)
    else $error("request taken during flag access");

endmodule // irq_ctrl

// ### irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_PEND0 = 16'hFFE0;
  localparam logic [15:0] IDX_PEND1 = 16'hFFE1;
  localparam logic [15:0] IDX_BLOCK0 = 16'hFFE4;
  localparam logic [15:0] IDX_BLOCK1 = 16'hFFE5;
  localparam logic [15:0] IDX_EDGE0 = 16'hFFEC;
  localparam logic [15:0] IDX_EDGE1 = 16'hFFED;
  localparam logic [15:0] IDX_PSW = 16'hFFEE;
  localparam logic [15:0] IDX_BITOP = 16'hFFEF;
  localparam logic [17:0] A_PEND0 = {IDX_PEND0, 2'h0};
  localparam logic [17:0] A_PEND1 = {IDX_PEND1, 2'h0};
  localparam logic [17:0] A_BLOCK0 = {IDX_BLOCK0, 2'h0};
  localparam logic [17:0] A_BLOCK1 = {IDX_BLOCK1, 2'h0};
  localparam logic [17:0] A_EDGE0 = {IDX_EDGE0, 2'h0};
  localparam logic [17:0] A_EDGE1 = {IDX_EDGE1, 2'h0};
  localparam logic [17:0] A_PSW = {IDX_PSW, 2'h0};
  localparam logic [17:0] A_BITOP = {IDX_BITOP, 2'h0};

  // ==========================================================================
  // Reset values and field layouts
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam logic [7:0] BLOCK_RST = 8'hFF;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h02;
  localparam logic [7:0] PSW_KEEP = 8'hD1;
  localparam logic [7:0] PSW_ONES = 8'h02;
  localparam int PSW_IE = 7;
  localparam logic [7:0] EDGE0_MASK = 8'hFC;
  localparam logic [7:0] EDGE1_MASK = 8'h03;
  localparam logic [3:0] PEND1_FILL = 4'h0;
  localparam logic [3:0] BLOCK1_FILL = 4'hF;
  localparam int BITOP_SET = 6;
  localparam int BITOP_CLR = 7;
  localparam int NREG_BIT = 5;

  // ==========================================================================
  // Sources
  localparam int NSRC = 12;
  localparam int NPIN = 4;
  localparam int NPERIPH = 7;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] WDT_INTERVAL = 2'h0;
  localparam logic [1:0] WDT_MODE1 = 2'h1;
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  // ==========================================================================
  // Timing, in CPU clocks of 50 ns
  localparam int SVC_MIN_CLK = 9;
  localparam int SVC_MAX_CLK = 19;
  localparam logic [4:0] AGE_LOAD = 5'(SVC_MIN_CLK - 2);
  localparam logic [4:0] AGE_TOP = 5'h1F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic allow_all;
    logic mask_all;
    logic return_from_service_instr;
    logic flag_instr;
    logic boundary;
    logic [7:0] restore_psw;
  } cpu_ctl_type;

  typedef struct packed {
    logic push_psw;
    logic push_pc;
    logic load_vec;
    logic nmi;
    logic [15:0] vector;
    logic [7:0] program_status_word;
  } ack_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PSW = 5'h02,
    ST_PC = 5'h04,
    ST_WAIT = 5'h08,
    ST_VEC = 5'h10
  } seq_type;

endpackage

// ### cpu_model.sv
`timescale 1ns/1ns
module cpu_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire irq_ctrl_pkg::ack_type ack,
  input wire logic allow_req,
  input wire logic return_from_service_instr_req,
  input wire logic mask_req,
  input wire logic flag_req,
  output irq_ctrl_pkg::cpu_ctl_type cpu_ctl
);
  // ========
  // Stacked status word
  logic [7:0] stack_psw_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stack_psw_ff <= irq_ctrl_pkg::PSW_RST;
    end else if (ack.push_psw) begin
      stack_psw_ff <= ack.program_status_word;
    end
  end
  // ========
  // Core control, at a boundary whenever rst_b is high
  always_comb begin
    cpu_ctl = '0;
    cpu_ctl.boundary = rst_b;
    cpu_ctl.allow_all = allow_req;
    cpu_ctl.return_from_service_instr = return_from_service_instr_req;
    cpu_ctl.mask_all = mask_req;
    cpu_ctl.flag_instr = flag_req;
    cpu_ctl.restore_psw = stack_psw_ff;
  end
endmodule // cpu_model

// ### test_mcu_interrupt_controller.sv
`timescale 1ns/1ns
module test_mcu_interrupt_controller;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs, bs;
  logic [31:0] rdata;
  logic [1:0] wdt_mode = 2'h0;
  logic watchdog_irq = 1'b0, allow_req = 1'b0, return_from_service_instr_req = 1'b0;
  logic mask_req = 1'b0, flag_req = 1'b0;
  logic [3:0] external_irq_pin = 4'h0;
  logic [6:0] periph_irq = 7'h00;
  logic [7:0] rd;
  irq_ctrl_pkg::cpu_ctl_type cpu_ctl;
  irq_ctrl_pkg::ack_type ack;
  int fails = 0, compares = 0, lat, gap;
  logic [17:0] ra [7] = '{irq_ctrl_pkg::A_PEND0, irq_ctrl_pkg::A_PEND1,
    irq_ctrl_pkg::A_BLOCK0, irq_ctrl_pkg::A_BLOCK1, irq_ctrl_pkg::A_EDGE0,
    irq_ctrl_pkg::A_EDGE1, irq_ctrl_pkg::A_PSW};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h02};
  always #25 ref_clk = ~ref_clk;
  irq_ctrl DUT (.ref_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .wdt_mode, .watchdog_irq,
    .external_irq_pin, .periph_irq, .cpu_ctl, .ack);
  cpu_model core (.ref_clk, .rst_b, .ack, .allow_req, .return_from_service_instr_req, .mask_req,
    .flag_req, .cpu_ctl);
  // ========
  // Bus and compare tasks
  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    bs = bresp;
  endtask
  task automatic rdreg(input logic [17:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata[7:0];
    rs = rresp;
  endtask
  task automatic pulse(input logic [6:0] p, input logic w, al, rt);
    @(posedge ref_clk);
    periph_irq <= p;
    watchdog_irq <= w;
    allow_req <= al;
    return_from_service_instr_req <= rt;
    @(posedge ref_clk);
    periph_irq <= 7'h00;
    watchdog_irq <= 1'b0;
    allow_req <= 1'b0;
    return_from_service_instr_req <= 1'b0;
  endtask
  task automatic await_ack();
    int ps;
    lat = 0;
    ps = 0;
    do begin
      @(posedge ref_clk);
      lat++;
      if (ack.push_psw) ps = lat;
      if (ack.push_pc) gap = lat - ps;
    end while (ack.load_vec !== 1'b1 && lat < 60);
  endtask
  task automatic finish_test();
    $display("Compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  // ========
  // Scenarios
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (ra[i]) begin
      rdreg(ra[i]);
      check("reset value", {8'h00, rd}, {8'h00, rv[i]});
    end
    rdreg(18'h00000);
    check("unmapped resp", 16'(rs), 16'h0002);
    wr(18'h00000, 8'h00);
    check("unmapped bresp", 16'(bs), 16'h0002);
    wr(irq_ctrl_pkg::A_BLOCK1, 8'h00);
    rdreg(irq_ctrl_pkg::A_BLOCK1);
    check("block1 fill", 16'(rd), 16'h00F0);
    wr(irq_ctrl_pkg::A_EDGE0, 8'h04);
    @(posedge ref_clk) external_irq_pin <= 4'h1;
    rdreg(irq_ctrl_pkg::A_PEND0);
    check("pin rise", 16'(rd), 16'h0002);
    wr(irq_ctrl_pkg::A_PEND0, 8'h00);
    @(posedge ref_clk) external_irq_pin <= 4'h0;
    rdreg(irq_ctrl_pkg::A_PEND0);
    check("pin fall", 16'(rd), 16'h0000);
    @(posedge ref_clk) wdt_mode <= 2'h1;
    wr(irq_ctrl_pkg::A_PEND0, 8'h00);
    rdreg(irq_ctrl_pkg::A_PEND0);
    check("wdt flag", 16'(rd), 16'h0000);
    rdreg(irq_ctrl_pkg::A_BLOCK0);
    check("wdt block read", 16'(rd), 16'h00FE);
    pulse(7'h00, 1'b1, 1'b0, 1'b0);
    await_ack();
    check("nmi vector", ack.vector, 16'h0004);
    check("nmi kind", 16'(ack.nmi), 16'h0001);
    check("nmi order", 16'(gap), 16'h0001);
    @(posedge ref_clk) wdt_mode <= 2'h0;
    wr(irq_ctrl_pkg::A_BLOCK0, 8'hBF);
    wr(irq_ctrl_pkg::A_PSW, 8'h82);
    pulse(7'h02, 1'b0, 1'b0, 1'b0);
    await_ack();
    check("latency", 16'(lat >= 9 && lat <= 19), 16'h0001);
    check("vector 6", ack.vector, 16'h0010);
    check("pushed psw", {8'h00, ack.program_status_word}, 16'h0082);
    check("push order", 16'(gap), 16'h0001);
    rdreg(irq_ctrl_pkg::A_PEND0);
    check("flag cleared", 16'(rd), 16'h0000);
    rdreg(irq_ctrl_pkg::A_PSW);
    check("enable cleared", 16'(rd), 16'h0002);
    wr(irq_ctrl_pkg::A_BLOCK0, 8'h9F);
    pulse(7'h03, 1'b0, 1'b0, 1'b0);
    rdreg(irq_ctrl_pkg::A_PEND0);
    check("held pending", 16'(rd), 16'h0060);
    pulse(7'h00, 1'b0, 1'b1, 1'b0);
    await_ack();
    check("first by priority", ack.vector, 16'h000E);
    pulse(7'h00, 1'b0, 1'b0, 1'b1);
    await_ack();
    check("second after return", ack.vector, 16'h0010);
    @(posedge ref_clk) flag_req <= 1'b1;
    pulse(7'h02, 1'b0, 1'b1, 1'b0);
    rdreg(irq_ctrl_pkg::A_PSW);
    check("held by access", {8'h00, rd}, 16'h0082);
    @(posedge ref_clk) flag_req <= 1'b0;
    await_ack();
    check("taken after access", ack.vector, 16'h0010);
    pulse(7'h00, 1'b0, 1'b1, 1'b0);
    @(posedge ref_clk) mask_req <= 1'b1;
    @(posedge ref_clk) mask_req <= 1'b0;
    rdreg(irq_ctrl_pkg::A_PSW);
    check("mask all", {8'h00, rd}, 16'h0002);
    finish_test();
  end
endmodule // test_mcu_interrupt_controller
